/* File: common/cspr_defines.vh */
// Purpose: constants for the core status, port and control register group
// Assumes: register index times four is the apb byte address
// Notes:   definitions only
`ifndef CSPR_DEFINES_VH
`define CSPR_DEFINES_VH

// ----------------------------------------
// register indexes
// ----------------------------------------
`define CSPR_IDX_STATUS      6'h03
`define CSPR_IDX_POINTER     6'h04
`define CSPR_IDX_PORT_A      6'h05
`define CSPR_IDX_PORT_B      6'h06
`define CSPR_IDX_POWER       6'h08
`define CSPR_IDX_WAKEUP      6'h09
`define CSPR_IDX_PC_HIGH_BUFFER      6'h0a
`define CSPR_IDX_PULLDOWN    6'h0b
`define CSPR_IDX_PB_PULLUP   6'h0c

// ----------------------------------------
// status field positions
// ----------------------------------------
`define CSPR_ST_CARRY        0
`define CSPR_ST_HALF_CARRY   1
`define CSPR_ST_ZERO         2
`define CSPR_ST_PD_N         3
`define CSPR_ST_TO_N         4
`define CSPR_ST_SPARE        5
`define CSPR_ST_BANK_LO      6
`define CSPR_ST_BANK_HI      7

// ----------------------------------------
// power control field positions
// ----------------------------------------
`define CSPR_PC_WDT_EN       7
`define CSPR_PC_LVD_EN       5
`define CSPR_PC_PA5_PU_N     4
`define CSPR_PC_LVR_EN       3

// ----------------------------------------
// pc high buffer field positions
// ----------------------------------------
`define CSPR_PCH_XSPD_STOP   6

// ----------------------------------------
// reset values
// ----------------------------------------
`define CSPR_RST_STATUS      8'h18
`define CSPR_RST_POINTER     8'h00
`define CSPR_RST_PORT        8'h00
`define CSPR_RST_POWER       8'h98
`define CSPR_RST_WAKEUP      6'h3f
`define CSPR_RST_PC_HOLD     3'h0
`define CSPR_RST_PULLDOWN    8'hff
`define CSPR_RST_PB_PULLUP   6'h3f

`endif

/* File: logic/cspr_regs.v */
// Purpose: core status, pointer, port data and power/pull control registers
// Assumes: core events and directions arrive on pclk; pins are asynchronous
// Notes:   apb slave with one wait state; all outputs registered
`timescale 1ns/1ps
`include "cspr_defines.vh"

// Overview of operation
// - carry set on add carry-out, on subtract when no borrow, else cleared.
// - half carry set on low-nibble carry, or no low-nibble borrow on subtract.
// - zero flag set when logical result is zero, cleared otherwise.
// - power-down flag set at reset and clear-watchdog, cleared by sleep.
// - timeout flag set at reset, clear-watchdog or sleep, cleared on timeout.
// - status bits 7:6 select one of four data banks, reset 00.
// - seven pointer bits select one of 128 locations in the bank.
// - status bit 5 and pointer bit 7 are plain storage, reset 0.
// - port read returns live pin level for input bits.
// - output bits read pin or latch per readback option.
// - port A write stores all eight latch bits.
// - port B write stores bits 5 to 0 into latches.
// - port B bits 7 and 6 are plain storage bits.
// - power bits 7, 5, 3 enable watchdog, voltage detect, voltage reset.
// - power bit 4 is active-low pull-up for port A bit 5, reset 1.
// - power bits 6, 2, 1, 0 are plain storage, reset 0.
// - wake-up bits 5 to 0 enable port B pin wake-up, reset 1.
// - pc high buffer bits 2:0 are write-only holding, reset 000.
// - writing 1 to buffer bit 6 stops crystal speed-up; write-only.
// - pull-down bits 3:0 are active-low port A pull-downs, reset 1.
// - pull-down bits 7:4 are active-low port B pull-downs, reset 1.
// - port B pull-up bits 5:0 are active low, reset 1.
// - pc bits 10:8 load from the buffer only when low pc byte changes.
// - bank bits ignored for special page direct accesses; indirect address keeps them.
module cspr_regs (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // core events
    input  wire        alu_add_valid,
    input  wire        alu_sub_valid,
    input  wire [7:0]  alu_opa,
    input  wire [7:0]  alu_opb,
    input  wire        logic_valid,
    input  wire [7:0]  logic_result,
    input  wire        clrwdt_exec,
    input  wire        sleep_exec,
    input  wire        wdt_timeout,
    input  wire        pcl_changed,
    input  wire        special_page_access,
    input  wire [6:0]  direct_addr_low,
    // port configuration
    input  wire [7:0]  port_a_is_output,
    input  wire [5:0]  port_b_is_output,
    input  wire        output_readback_option,
    // pins
    input  wire [7:0]  port_a_pin_in,
    input  wire [5:0]  port_b_pin_in,
    output reg  [7:0]  port_a_out,
    output reg  [7:0]  port_a_oe_n,
    output reg  [5:0]  port_b_out,
    output reg  [5:0]  port_b_oe_n,
    // control outputs
    output reg  [1:0]  bank_select,
    output reg  [8:0]  indirect_address,
    output reg  [8:0]  data_address,
    output reg  [2:0]  pc_high,
    output reg         watchdog_enable,
    output reg         low_voltage_detect_enable,
    output reg         low_voltage_reset_enable,
    output reg         pa5_pullup_n,
    output reg  [5:0]  port_b_data_wakeup_enable_bits,
    output reg  [3:0]  port_a_data_pulldown_n,
    output reg  [3:0]  port_b_data_pulldown_n,
    output reg  [5:0]  port_b_data_pullup_n,
    output reg         crystal_speedup_stop
);

    // ----------------------------------------
    // storage
    // ----------------------------------------
    reg  [7:0] status;
    reg  [7:0] pointer;
    reg  [7:0] port_a_latch;
    reg  [7:0] port_b_latch;
    reg  [7:0] power_control;
    reg  [5:0] wakeup;
    reg  [2:0] pc_high_hold;
    reg  [7:0] pull_down;
    reg  [5:0] pb_pullup;
    reg  [7:0] pa_meta;
    reg  [7:0] pa_sync;
    reg  [5:0] pb_meta;
    reg  [5:0] pb_sync;

    reg  [7:0] next_status;
    reg  [7:0] rd_value;
    reg        rd_hit;
    reg  [8:0] sum9;
    reg  [4:0] sum5;

    wire       access = psel & penable & ~pready;
    wire       wr_en  = psel & penable & pready & pwrite;
    wire [5:0] index  = paddr[7:2];
    wire [1:0] bank_bits = status[`CSPR_ST_BANK_HI:`CSPR_ST_BANK_LO];
    wire [7:0] wbyte  = pwdata[7:0];

    // pin or latch per bit for one port
    function [7:0] port_read;
        input [7:0] pin;
        input [7:0] latch;
        input [7:0] is_out;
        input       opt;
        begin
            port_read = (is_out & (opt ? latch : pin)) | (~is_out & pin);
        end
    endfunction

    // bank bits sit above a seven-bit in-bank address
    function [8:0] bank_join;
        input [1:0] bank;
        input [6:0] low;
        begin
            bank_join = {bank, low};
        end
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // only the second stage is read, so reads see pins two edges late
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_meta <= 8'h00;
            pa_sync <= 8'h00;
            pb_meta <= 6'h00;
            pb_sync <= 6'h00;
        end else begin
            pa_meta <= port_a_pin_in;
            pa_sync <= pa_meta;
            pb_meta <= port_b_pin_in;
            pb_sync <= pb_meta;
        end
    end

    // ----------------------------------------
    // status next value
    // ----------------------------------------
    // core events are applied after the bus write so a hardware set
    // in the same cycle as a software clear is never lost
    always @* begin
        next_status = status;
        sum9 = 9'h000;
        sum5 = 5'h00;
        if (wr_en && index == `CSPR_IDX_STATUS) begin
            next_status = wbyte;
        end
        if (alu_add_valid) begin
            sum9 = {1'b0, alu_opa} + {1'b0, alu_opb};
            sum5 = {1'b0, alu_opa[3:0]} + {1'b0, alu_opb[3:0]};
        end else if (alu_sub_valid) begin
            // a - b as a + ~b + 1: carry out means no borrow
            sum9 = {1'b0, alu_opa} + {1'b0, ~alu_opb} + 9'h001;
            sum5 = {1'b0, alu_opa[3:0]} + {1'b0, ~alu_opb[3:0]} + 5'h01;
        end
        if (alu_add_valid || alu_sub_valid) begin
            next_status[`CSPR_ST_CARRY]      = sum9[8];
            next_status[`CSPR_ST_HALF_CARRY] = sum5[4];
        end
        if (logic_valid) begin
            next_status[`CSPR_ST_ZERO] = (logic_result == 8'h00);
        end
        if (sleep_exec) begin
            next_status[`CSPR_ST_PD_N] = 1'b0;
            next_status[`CSPR_ST_TO_N] = 1'b1;
        end
        if (clrwdt_exec) begin
            next_status[`CSPR_ST_PD_N] = 1'b1;
            next_status[`CSPR_ST_TO_N] = 1'b1;
        end
        if (wdt_timeout) begin
            next_status[`CSPR_ST_TO_N] = 1'b0;
        end
    end

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status        <= `CSPR_RST_STATUS;
            pointer       <= `CSPR_RST_POINTER;
            port_a_latch  <= `CSPR_RST_PORT;
            port_b_latch  <= `CSPR_RST_PORT;
            power_control <= `CSPR_RST_POWER;
            wakeup        <= `CSPR_RST_WAKEUP;
            pc_high_hold  <= `CSPR_RST_PC_HOLD;
            pull_down     <= `CSPR_RST_PULLDOWN;
            pb_pullup     <= `CSPR_RST_PB_PULLUP;
            crystal_speedup_stop <= 1'b0;
        end else begin
            status <= next_status;
            crystal_speedup_stop <= 1'b0;
            if (wr_en) begin
                case (index)
                    `CSPR_IDX_POINTER: begin
                        pointer <= wbyte;
                    end
                    `CSPR_IDX_PORT_A: begin
                        port_a_latch <= wbyte;
                    end
                    `CSPR_IDX_PORT_B: begin
                        port_b_latch <= wbyte;
                    end
                    `CSPR_IDX_POWER: begin
                        power_control <= wbyte;
                    end
                    `CSPR_IDX_WAKEUP: begin
                        wakeup <= wbyte[5:0];
                    end
                    `CSPR_IDX_PC_HIGH_BUFFER: begin
                        pc_high_hold <= wbyte[2:0];
                        // one-cycle stop pulse, nothing held to read back
                        crystal_speedup_stop <= wbyte[`CSPR_PCH_XSPD_STOP];
                    end
                    `CSPR_IDX_PULLDOWN: begin
                        pull_down <= wbyte;
                    end
                    `CSPR_IDX_PB_PULLUP: begin
                        pb_pullup <= wbyte[5:0];
                    end
                    default: begin
                        pointer <= pointer;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // read decode
    // ----------------------------------------
    always @* begin
        rd_value = 8'h00;
        rd_hit   = 1'b1;
        case (index)
            `CSPR_IDX_STATUS:    rd_value = status;
            `CSPR_IDX_POINTER:   rd_value = pointer;
            `CSPR_IDX_PORT_A: begin
                rd_value = port_read(pa_sync, port_a_latch, port_a_is_output,
                                     output_readback_option);
            end
            `CSPR_IDX_PORT_B: begin
                // bits 7:6 have no pin, they read their stored value
                rd_value = port_read({2'b00, pb_sync}, {2'b00, port_b_latch[5:0]},
                                     {2'b00, port_b_is_output},
                                     output_readback_option);
                rd_value[7:6] = port_b_latch[7:6];
            end
            `CSPR_IDX_POWER:     rd_value = power_control;
            `CSPR_IDX_WAKEUP:    rd_value = {2'b00, wakeup};
            `CSPR_IDX_PC_HIGH_BUFFER:    rd_value = 8'h00;
            `CSPR_IDX_PULLDOWN:  rd_value = pull_down;
            `CSPR_IDX_PB_PULLUP: rd_value = {2'b00, pb_pullup};
            default:             rd_hit   = 1'b0;
        endcase
    end

    // ----------------------------------------
    // apb handshake
    // ----------------------------------------
    // one wait state keeps pready, prdata and pslverr all registered
    // prdata keeps its last answer between transfers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= access;
            pslverr <= access & ~rd_hit;
            if (access && !pwrite) begin
                prdata <= {24'h00_0000, rd_value};
            end else if (access) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------
    // control and pin outputs
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_a_out                <= `CSPR_RST_PORT;
            port_a_oe_n               <= 8'hff;
            port_b_out                <= 6'h00;
            port_b_oe_n               <= 6'h3f;
            bank_select               <= 2'b00;
            indirect_address          <= 9'h000;
            data_address              <= 9'h000;
            pc_high                   <= `CSPR_RST_PC_HOLD;
            watchdog_enable           <= 1'b1;
            low_voltage_detect_enable <= 1'b0;
            low_voltage_reset_enable  <= 1'b1;
            pa5_pullup_n              <= 1'b1;
            port_b_data_wakeup_enable_bits  <= `CSPR_RST_WAKEUP;
            port_a_data_pulldown_n          <= 4'hf;
            port_b_data_pulldown_n          <= 4'hf;
            port_b_data_pullup_n            <= `CSPR_RST_PB_PULLUP;
        end else begin
            port_a_out  <= port_a_latch;
            port_a_oe_n <= ~port_a_is_output;
            port_b_out  <= port_b_latch[5:0];
            port_b_oe_n <= ~port_b_is_output;
            bank_select <= bank_bits;
            indirect_address <= bank_join(bank_bits, pointer[6:0]);
            // special pages carry their own decode, so bank bits drop out
            data_address <= special_page_access ? {2'b00, direct_addr_low}
                          : bank_join(bank_bits, direct_addr_low);
            if (pcl_changed) begin
                pc_high <= pc_high_hold;
            end
            watchdog_enable           <= power_control[`CSPR_PC_WDT_EN];
            low_voltage_detect_enable <= power_control[`CSPR_PC_LVD_EN];
            low_voltage_reset_enable  <= power_control[`CSPR_PC_LVR_EN];
            pa5_pullup_n              <= power_control[`CSPR_PC_PA5_PU_N];
            port_b_data_wakeup_enable_bits  <= wakeup;
            port_a_data_pulldown_n          <= pull_down[3:0];
            port_b_data_pulldown_n          <= pull_down[7:4];
            port_b_data_pullup_n            <= pb_pullup;
        end
    end

endmodule

/* File: dv/cspr_props.sv */
// Purpose: protocol and output checks for the register group
// Assumes: bound to cspr_regs, single pclk domain
// Notes:   derived outputs may trail their register by one cycle
`timescale 1ns/1ps
module cspr_props (
    // clock and reset
    input logic        pclk,
    input logic        presetn,
    // apb
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [7:0]  paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    // core side and outputs
    input logic        pcl_changed,
    input logic [2:0]  pc_high,
    input logic [1:0]  bank_select,
    input logic        watchdog_enable,
    input logic        crystal_speedup_stop
);
    wire       done = psel && penable && pready && pwrite;
    wire [5:0] idx  = paddr[7:2];
    wire       stop_wr = done && idx == 6'h0a && pwdata[6];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    one_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready not one cycle after access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    slverr_qual_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    rdata_upper_a: assert property (pready |-> prdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    pch_hold_a: assert property (!pcl_changed |=> $stable(pc_high))
        else $error("pc high moved without low byte change");
    xspd_pulse_a: assert property (stop_wr |=> crystal_speedup_stop)
        else $error("speed-up stop missing after write");
    xspd_cause_a: assert property (crystal_speedup_stop |-> $past(stop_wr))
        else $error("speed-up stop without write");
    wdt_cause_a: assert property ($changed(watchdog_enable) |->
        $past(done && idx == 6'h08) || $past(done && idx == 6'h08, 2))
        else $error("watchdog enable changed without write");
    bank_cause_a: assert property ($changed(bank_select) |->
        $past(done && idx == 6'h03) || $past(done && idx == 6'h03, 2))
        else $error("bank select changed without write");
endmodule
bind cspr_regs cspr_props chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pcl_changed, .pc_high, .bank_select, .watchdog_enable,
    .crystal_speedup_stop);

/* File: dv/cspr_pin_model.sv */
// Purpose: pins of ports A and B with pulls and external drivers
// Assumes: oe_n low means the block drives the pin
// Notes:   an undriven pin with no pull toggles every cycle, never holds
`timescale 1ns/1ps
module cspr_pin_model (
    // clock
    input  logic       pclk,
    // block side
    input  logic [7:0] port_a_out,
    input  logic [7:0] port_a_oe_n,
    input  logic [5:0] port_b_out,
    input  logic [5:0] port_b_oe_n,
    input  logic       pa5_pullup_n,
    input  logic [3:0] port_a_data_pulldown_n,
    input  logic [3:0] port_b_data_pulldown_n,
    input  logic [5:0] port_b_data_pullup_n,
    // external drivers
    input  logic       ext_on,
    input  logic [7:0] ext_a,
    input  logic [5:0] ext_b,
    // pin levels
    output logic [7:0] port_a_pin_in,
    output logic [5:0] port_b_pin_in
);
    logic tog = 1'b0;
    always @(posedge pclk) tog <= ~tog;
    function automatic logic lvl(input logic oe_n, o, pu_n, pd_n, e_on, e, fl);
        // a strong outside driver wins even over a driven pin
        if (e_on) return e;
        if (!oe_n) return o;
        if (!pu_n) return 1'b1;
        if (!pd_n) return 1'b0;
        return fl;
    endfunction
    always_comb begin
        for (int i = 0; i < 8; i++)
            port_a_pin_in[i] = lvl(port_a_oe_n[i], port_a_out[i], (i == 5) ? pa5_pullup_n : 1'b1,
                (i < 4) ? port_a_data_pulldown_n[i%4] : 1'b1, ext_on, ext_a[i], tog);
        for (int i = 0; i < 6; i++)
            port_b_pin_in[i] = lvl(port_b_oe_n[i], port_b_out[i], port_b_data_pullup_n[i],
                (i < 4) ? port_b_data_pulldown_n[i%4] : 1'b1, ext_on, ext_b[i], tog);
    end
endmodule

/* File: dv/tb_top.sv */
// Purpose: directed register, event and pin tests for the register group
// Assumes: apb slave answers with one wait state, bench waits anyway
// Notes:   pins come from the pin model, ext drivers on or off together
`timescale 1ns/1ps
`include "cspr_defines.vh"
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, ext_on;
    logic        alu_add_valid, alu_sub_valid, logic_valid, clrwdt_exec, sleep_exec;
    logic        wdt_timeout, pcl_changed, special_page_access, output_readback_option;
    logic        watchdog_enable, low_voltage_detect_enable, low_voltage_reset_enable;
    logic        pa5_pullup_n, crystal_speedup_stop, ec, eh;
    logic [7:0]  paddr, alu_opa, alu_opb, logic_result, port_a_is_output, ext_a;
    logic [7:0]  port_a_pin_in, port_a_out, port_a_oe_n;
    logic [5:0]  port_b_is_output, port_b_pin_in, port_b_out, port_b_oe_n, ext_b;
    logic [5:0]  port_b_data_wakeup_enable_bits, port_b_data_pullup_n;
    logic [3:0]  port_a_data_pulldown_n, port_b_data_pulldown_n;
    logic [6:0]  direct_addr_low;
    logic [8:0]  indirect_address, data_address;
    logic [2:0]  pc_high;
    logic [1:0]  bank_select;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  opa [5] = '{8'h0f, 8'hf0, 8'h05, 8'h03, 8'h10};
    logic [7:0]  opb [5] = '{8'h01, 8'h10, 8'h03, 8'h05, 8'h01};
    int          num_errors = 0;
    int          checks_done = 0;

    cspr_regs dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .alu_add_valid, .alu_sub_valid, .alu_opa, .alu_opb, .logic_valid,
        .logic_result, .clrwdt_exec, .sleep_exec, .wdt_timeout, .pcl_changed,
        .special_page_access, .direct_addr_low, .port_a_is_output, .port_b_is_output,
        .output_readback_option, .port_a_pin_in, .port_b_pin_in, .port_a_out, .port_a_oe_n,
        .port_b_out, .port_b_oe_n, .bank_select, .indirect_address, .data_address, .pc_high,
        .watchdog_enable, .low_voltage_detect_enable, .low_voltage_reset_enable, .pa5_pullup_n,
        .port_b_data_wakeup_enable_bits, .port_a_data_pulldown_n, .port_b_data_pulldown_n, .port_b_data_pullup_n,
        .crystal_speedup_stop);
    cspr_pin_model pins_u (.pclk, .port_a_out, .port_a_oe_n, .port_b_out, .port_b_oe_n,
        .pa5_pullup_n, .port_a_data_pulldown_n, .port_b_data_pulldown_n, .port_b_data_pullup_n, .ext_on, .ext_a,
        .ext_b, .port_a_pin_in, .port_b_pin_in);

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic print_verdict;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp, mask);
        checks_done++;
        if (((got ^ exp) & mask) !== 32'h0000_0000) begin
            num_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp & mask);
        end
    endtask
    task automatic apb(input logic w, input logic [5:0] i, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            $display("ERROR %0t no pready", $time);
            print_verdict();
        end
    endtask
    task automatic rdc(input logic [5:0] i, input logic [7:0] e, m);
        apb(1'b0, i, 8'h00);
        chk(rd, {24'h00_0000, e}, {24'hff_ffff, m});
    endtask
    // derived outputs and synchronised pins need a few edges to land
    task automatic wt;
        repeat (4) @(posedge pclk);
    endtask
    task automatic ev(input int k, input logic [7:0] a, b);
        @(posedge pclk);
        alu_opa <= a;
        alu_opb <= b;
        logic_result <= a;
        case (k)
            0: alu_add_valid <= 1'b1;
            1: alu_sub_valid <= 1'b1;
            2: logic_valid <= 1'b1;
            3: sleep_exec <= 1'b1;
            4: wdt_timeout <= 1'b1;
            5: clrwdt_exec <= 1'b1;
            default: pcl_changed <= 1'b1;
        endcase
        @(posedge pclk);
        {alu_add_valid, alu_sub_valid, logic_valid, sleep_exec} <= 4'h0;
        {wdt_timeout, clrwdt_exec, pcl_changed} <= 3'h0;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, ext_on, special_page_access} = 6'h00;
        {alu_add_valid, alu_sub_valid, logic_valid, sleep_exec} = 4'h0;
        {wdt_timeout, clrwdt_exec, pcl_changed, output_readback_option} = 4'h0;
        {paddr, alu_opa, alu_opb, logic_result, ext_a} = 40'h00_0000_0000;
        {port_a_is_output, port_b_is_output, ext_b} = 20'h0_0000;
        pwdata = 32'h0000_0000;
        direct_addr_low = 7'h12;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`CSPR_IDX_STATUS, 8'h18, 8'hf8);
        rdc(`CSPR_IDX_POINTER, 8'h00, 8'h80);
        rdc(`CSPR_IDX_POWER, 8'h98, 8'hff);
        rdc(`CSPR_IDX_WAKEUP, 8'h3f, 8'h3f);
        rdc(`CSPR_IDX_PC_HIGH_BUFFER, 8'h00, 8'hff);
        rdc(`CSPR_IDX_PULLDOWN, 8'hff, 8'hff);
        rdc(`CSPR_IDX_PB_PULLUP, 8'h3f, 8'h3f);
        chk({watchdog_enable, low_voltage_detect_enable, low_voltage_reset_enable,
            pa5_pullup_n}, 4'hb, 4'hf);
        apb(1'b0, 6'h3f, 8'h00);
        chk(er, 1'b1, 1'b1);
        chk(rd, 32'h0000_0000, 32'hffff_ffff);
        apb(1'b1, `CSPR_IDX_POWER, 8'h6f);
        rdc(`CSPR_IDX_POWER, 8'h6f, 8'hff);
        wt;
        chk({watchdog_enable, low_voltage_detect_enable, low_voltage_reset_enable,
            pa5_pullup_n}, 4'h6, 4'hf);
        for (int b = 0; b < 4; b++) begin
            apb(1'b1, `CSPR_IDX_STATUS, {b[1:0], 6'h20});
            rdc(`CSPR_IDX_STATUS, {b[1:0], 6'h20}, 8'he0);
            wt;
            chk(bank_select, b[1:0], 2'h3);
        end
        apb(1'b1, `CSPR_IDX_POINTER, 8'h85);
        rdc(`CSPR_IDX_POINTER, 8'h85, 8'hff);
        wt;
        chk(indirect_address, 9'h185, 9'h1ff);
        chk(data_address, 9'h192, 9'h1ff);
        special_page_access <= 1'b1;
        wt;
        chk(data_address, 9'h012, 9'h1ff);
        for (int i = 0; i < 5; i++) begin
            ev(i > 1, opa[i], opb[i]);
            ec = (i > 1) ? (opa[i] >= opb[i]) : (9'(opa[i]) + 9'(opb[i]) > 9'h0ff);
            eh = (i > 1) ? (opa[i][3:0] >= opb[i][3:0])
                         : (5'(opa[i][3:0]) + 5'(opb[i][3:0]) > 5'h0f);
            rdc(`CSPR_IDX_STATUS, {6'h00, eh, ec}, 8'h03);
        end
        ev(2, 8'h00, 8'h00);
        rdc(`CSPR_IDX_STATUS, 8'h04, 8'h04);
        ev(2, 8'h10, 8'h00);
        rdc(`CSPR_IDX_STATUS, 8'h00, 8'h04);
        ev(3, 8'h00, 8'h00);
        rdc(`CSPR_IDX_STATUS, 8'h10, 8'h18);
        ev(4, 8'h00, 8'h00);
        rdc(`CSPR_IDX_STATUS, 8'h00, 8'h18);
        ev(5, 8'h00, 8'h00);
        rdc(`CSPR_IDX_STATUS, 8'h18, 8'h18);
        port_a_is_output <= 8'hff;
        output_readback_option <= 1'b1;
        ext_on <= 1'b1;
        ext_a <= 8'h3c;
        ext_b <= 6'h15;
        apb(1'b1, `CSPR_IDX_PORT_A, 8'ha5);
        wt;
        chk(port_a_out, 8'ha5, 8'hff);
        rdc(`CSPR_IDX_PORT_A, 8'ha5, 8'hff);
        output_readback_option <= 1'b0;
        wt;
        rdc(`CSPR_IDX_PORT_A, 8'h3c, 8'hff);
        port_a_is_output <= 8'h00;
        wt;
        rdc(`CSPR_IDX_PORT_A, 8'h3c, 8'hff);
        rdc(`CSPR_IDX_PORT_B, 8'h15, 8'h3f);
        ext_on <= 1'b0;
        apb(1'b1, `CSPR_IDX_PULLDOWN, 8'hf0);
        apb(1'b1, `CSPR_IDX_PB_PULLUP, 8'h00);
        wt;
        rdc(`CSPR_IDX_PORT_A, 8'h20, 8'h2f);
        rdc(`CSPR_IDX_PORT_B, 8'h3f, 8'h3f);
        apb(1'b1, `CSPR_IDX_PULLDOWN, 8'h0f);
        apb(1'b1, `CSPR_IDX_PB_PULLUP, 8'h3f);
        wt;
        rdc(`CSPR_IDX_PORT_B, 8'h00, 8'h0f);
        port_b_is_output <= 6'h3f;
        output_readback_option <= 1'b1;
        apb(1'b1, `CSPR_IDX_PORT_B, 8'hea);
        wt;
        chk(port_b_out, 6'h2a, 6'h3f);
        rdc(`CSPR_IDX_PORT_B, 8'hea, 8'hff);
        apb(1'b1, `CSPR_IDX_WAKEUP, 8'h15);
        rdc(`CSPR_IDX_WAKEUP, 8'h15, 8'h3f);
        wt;
        chk(port_b_data_wakeup_enable_bits, 6'h15, 6'h3f);
        apb(1'b1, `CSPR_IDX_PC_HIGH_BUFFER, 8'h45);
        rdc(`CSPR_IDX_PC_HIGH_BUFFER, 8'h00, 8'hff);
        wt;
        chk(pc_high, 3'h0, 3'h7);
        ev(6, 8'h00, 8'h00);
        wt;
        chk(pc_high, 3'h5, 3'h7);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rdc(`CSPR_IDX_POWER, 8'h98, 8'hff);
        print_verdict();
    end
endmodule
